// file: hdl/buck_consts.svh
`ifndef BUCK_CONSTS_SVH
`define BUCK_CONSTS_SVH

// ============================================================
// clock and switching rate
`define CLK_HZ          32'h0bebc200
`define SWITCH_HZ       32'h00055730
`define NS_PER_S        32'h3b9aca00
`define CLK_PERIOD_NS   (`NS_PER_S / `CLK_HZ)
`define CYCLE_CLKS      (`CLK_HZ / `SWITCH_HZ)
`define OSC_W           10

// ============================================================
// non-overlap gap between the two switches
`define DEAD_NS         32'h0000000a
`define DEAD_CLKS       ((`DEAD_NS + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)
`define DEAD_W          3

// ============================================================
// soft-start ramp and regulation reference, 1 mV per code
`define SS_TIME_MS      32'h00000005
`define CLK_PER_MS      (`CLK_HZ / 32'h000003e8)
`define SS_CLKS_DEF     (`SS_TIME_MS * `CLK_PER_MS)
`define CODE_W          10
`define REF_CODE        10'h254
`define RAMP_MAX        10'h3ff

// ============================================================
// protection counts in switching cycles
`define WAIT_W          16
`define OC_CNT_W        10
`define OC_WAIT_CYC     10'h200
`define OC_RESTART_CYC  16'h4000
`define TH_HICCUP_CYC   16'h8000
`define WAIT_LAST       16'hffff

`endif

// file: hdl/buck_pkg.sv
package buck_pkg;

    // ========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_PREBIAS,
        ST_RUN,
        ST_OC_HICCUP,
        ST_THERMAL
    } seq_state_t;

    // ========================================================
    // power stage phase
    typedef enum logic [1:0] {
        PH_OFF,
        PH_HS,
        PH_LS
    } phase_t;

endpackage : buck_pkg

// file: hdl/cycle_counter.sv
module cycle_counter #(
    parameter int unsigned      WIDTH = 10,
    parameter logic [WIDTH-1:0] LAST  = '1
) (
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    // control
    input  wire logic             clr_in,
    input  wire logic             inc_in,
    // status
    output logic [WIDTH-1:0]      count_out,
    output logic                  wrap_out
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } cnt_state_t;

    cnt_state_t q;
    cnt_state_t n;

    // ========================================================
    // next count
    always_comb begin
        n = q;
        if (clr_in) begin
            n.count = '0;
        end else if (inc_in) begin
            if (q.count == LAST) begin
                n.count = '0;
            end else begin
                n.count = q.count + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // outputs
    assign count_out = q.count;
    assign wrap_out  = inc_in && !clr_in && (q.count == LAST);

endmodule : cycle_counter

// file: hdl/soft_start_ramp.sv
`include "buck_consts.svh"

module soft_start_ramp #(
    parameter int unsigned SS_CLKS = `SS_CLKS_DEF
) (
    // clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 sys_rst_in,
    // control
    input  wire logic                 clear_in,
    input  wire logic                 run_in,
    // ramp level
    output logic [`CODE_W-1:0]        ramp_out
);

    // clocks per code step so the reference code is met at SS_CLKS
    localparam int unsigned STEP = SS_CLKS / `REF_CODE;

    typedef struct packed {
        logic [31:0]        div;
        logic [`CODE_W-1:0] ramp;
    } ramp_state_t;

    ramp_state_t q;
    ramp_state_t n;

    // ========================================================
    // ramp generator, saturates at full scale
    always_comb begin
        n = q;
        if (clear_in) begin
            n.div  = '0;
            n.ramp = '0;
        end else if (run_in && (q.ramp != `RAMP_MAX)) begin
            if (q.div >= STEP - 32'h1) begin
                n.div  = '0;
                n.ramp = q.ramp + 1'b1;
            end else begin
                n.div = q.div + 32'h1;
            end
        end
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign ramp_out = q.ramp;

endmodule : soft_start_ramp

// file: hdl/buck_switch_sequencer.sv
`include "buck_consts.svh"

module buck_switch_sequencer #(
    parameter int unsigned SS_CLKS = `SS_CLKS_DEF
) (
    // clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 sys_rst_in,
    // supervisory comparators
    input  wire logic                 enable_in,
    input  wire logic                 supply_ok_in,
    input  wire logic                 boot_ok_in,
    input  wire logic                 thermal_hot_in,
    input  wire logic                 thermal_cool_in,
    // regulation comparators
    input  wire logic                 ss_above_feedback_sense_in,
    input  wire logic                 peak_trip_in,
    input  wire logic                 overshoot_high_in,
    input  wire logic                 overshoot_low_in,
    // low-side current comparators
    input  wire logic                 valley_over_in,
    input  wire logic                 sink_limit_in,
    // gate commands
    output logic                      hs_on_out,
    output logic                      ls_on_out,
    // regulation target
    output logic [`CODE_W-1:0]        ss_ramp_out,
    output logic [`CODE_W-1:0]        target_out,
    // status
    output logic                      cycle_start_out,
    output logic                      switching_out,
    output logic                      hiccup_out,
    output logic                      thermal_out,
    output logic                      overshoot_mask_out
);

    typedef struct packed {
        buck_pkg::seq_state_t state;
        buck_pkg::phase_t     cur;
        logic [`DEAD_W-1:0]   dead;
        logic                 hs_req;
        logic                 skip;
        logic                 sink_block;
        logic                 mask;
        logic [`OC_CNT_W-1:0] oc_cnt;
        logic [`CODE_W-1:0]   target;
        logic                 hs;
        logic                 ls;
    } seq_regs_t;

    seq_regs_t q;
    seq_regs_t n;

    logic                  cycle_tick;
    logic [`WAIT_W-1:0]    wait_cnt;
    logic                  wait_inc;
    logic                  wait_clr;
    logic                  oc_done;
    logic                  th_done;
    logic                  ramp_clear;
    logic                  ramp_run;
    buck_pkg::phase_t      want;

    // ========================================================
    // switching cycle time base
    cycle_counter #(
        .WIDTH (`OSC_W),
        .LAST  (`OSC_W'(`CYCLE_CLKS - 32'h1))
    ) u_osc (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .clr_in     (1'b0),
        .inc_in     (1'b1),
        .count_out  (),
        .wrap_out   (cycle_tick)
    );

    // ========================================================
    // hiccup and thermal wait counter, counts switching cycles
    assign wait_inc = cycle_tick
                   && ((q.state == buck_pkg::ST_OC_HICCUP)
                    || ((q.state == buck_pkg::ST_THERMAL)
                     && thermal_cool_in && !thermal_hot_in));
    assign wait_clr = ((q.state != buck_pkg::ST_OC_HICCUP)
                    && (q.state != buck_pkg::ST_THERMAL))
                   || thermal_hot_in;

    cycle_counter #(
        .WIDTH (`WAIT_W),
        .LAST  (`WAIT_LAST)
    ) u_wait (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .clr_in     (wait_clr),
        .inc_in     (wait_inc),
        .count_out  (wait_cnt),
        .wrap_out   ()
    );

    // wait completion flags
    assign oc_done = wait_inc
                  && (wait_cnt == `OC_RESTART_CYC - 1'b1);
    assign th_done = wait_inc
                  && (wait_cnt == `TH_HICCUP_CYC - 1'b1);

    // ========================================================
    // soft-start ramp, cleared whenever not starting or running
    assign ramp_clear = (q.state != buck_pkg::ST_PREBIAS)
                     && (q.state != buck_pkg::ST_RUN);
    assign ramp_run   = !ramp_clear;

    soft_start_ramp #(
        .SS_CLKS (SS_CLKS)
    ) u_ramp (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .clear_in   (ramp_clear),
        .run_in     (ramp_run),
        .ramp_out   (ss_ramp_out)
    );

    // ========================================================
    // sequencer, cycle decision and gate non-overlap
    always_comb begin
        n    = q;
        want = buck_pkg::PH_OFF;

        // regulation target: lower of ramp and reference
        if (ss_ramp_out < `REF_CODE) begin
            n.target = ss_ramp_out;
        end else begin
            n.target = `REF_CODE;
        end

        // overshoot mask with hysteresis, set wins
        if (overshoot_high_in) begin
            n.mask = 1'b1;
        end else if (overshoot_low_in) begin
            n.mask = 1'b0;
        end

        // state sequencing
        case (q.state)
            buck_pkg::ST_OFF: begin
                if (enable_in && supply_ok_in) begin
                    n.state = buck_pkg::ST_PREBIAS;
                end
            end
            buck_pkg::ST_PREBIAS: begin
                if (ss_above_feedback_sense_in) begin
                    n.state = buck_pkg::ST_RUN;
                end
            end
            buck_pkg::ST_RUN: begin
                if (cycle_tick && valley_over_in
                        && (q.oc_cnt == `OC_WAIT_CYC)) begin
                    n.state = buck_pkg::ST_OC_HICCUP;
                end
            end
            buck_pkg::ST_OC_HICCUP: begin
                if (oc_done) begin
                    n.state = buck_pkg::ST_PREBIAS;
                end
            end
            buck_pkg::ST_THERMAL: begin
                if (th_done) begin
                    n.state = buck_pkg::ST_PREBIAS;
                end
            end
            default: begin
                n.state = buck_pkg::ST_OFF;
            end
        endcase

        // overtemperature overrides any active state
        if (thermal_hot_in && (q.state != buck_pkg::ST_OFF)) begin
            n.state = buck_pkg::ST_THERMAL;
        end
        // disable and lockout override everything
        if (!enable_in || !supply_ok_in) begin
            n.state = buck_pkg::ST_OFF;
        end

        // consecutive overload cycle count, sampled at cycle end
        if (n.state != buck_pkg::ST_RUN) begin
            n.oc_cnt = '0;
        end else if (cycle_tick) begin
            if (valley_over_in) begin
                n.oc_cnt = q.oc_cnt + 1'b1;
            end else begin
                n.oc_cnt = '0;
            end
        end

        // per-cycle decision; in run a cycle that starts with valley over limit skips its high-side pulse
        if (n.state != buck_pkg::ST_RUN) begin
            n.hs_req     = 1'b0;
            n.skip       = 1'b0;
            n.sink_block = 1'b0;
        end else begin
            if (cycle_tick || (q.state != buck_pkg::ST_RUN)) begin
                n.skip       = valley_over_in;
                n.hs_req     = !valley_over_in;
                n.sink_block = 1'b0;
            end
            // no forced off time: hs_req holds across cycles
            if (peak_trip_in) begin
                n.hs_req = 1'b0;
            end
            if (!boot_ok_in) begin
                n.hs_req = 1'b0;
            end
            if (n.mask) begin
                n.hs_req = 1'b0;
            end
            if (sink_limit_in && (q.cur == buck_pkg::PH_LS)) begin
                n.sink_block = 1'b1;
            end
            if (n.sink_block) begin
                want = buck_pkg::PH_OFF;
            end else if (n.hs_req) begin
                want = buck_pkg::PH_HS;
            end else begin
                want = buck_pkg::PH_LS;
            end
        end

        // break before make with a timed gap
        if (q.cur != buck_pkg::PH_OFF) begin
            if (want != q.cur) begin
                n.cur  = buck_pkg::PH_OFF;
                n.dead = `DEAD_W'(`DEAD_CLKS);
            end
        end else if (q.dead != '0) begin
            n.dead = q.dead - 1'b1;
        end else begin
            n.cur = want;
        end
        n.hs = (n.cur == buck_pkg::PH_HS);
        n.ls = (n.cur == buck_pkg::PH_LS);
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ========================================================
    // outputs
    assign hs_on_out          = q.hs;
    assign ls_on_out          = q.ls;
    assign target_out         = q.target;
    assign cycle_start_out    = cycle_tick;
    assign switching_out      = (q.state == buck_pkg::ST_RUN);
    assign hiccup_out         = (q.state == buck_pkg::ST_OC_HICCUP);
    assign thermal_out        = (q.state == buck_pkg::ST_THERMAL);
    assign overshoot_mask_out = q.mask;

    // ========================================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_sink_trip;
        sink_limit_in && ls_on_out && !cycle_tick
        && (q.state == buck_pkg::ST_RUN) && enable_in && supply_ok_in
        && !thermal_hot_in;
    endsequence

    sequence s_clean_start;
        cycle_tick && (q.state == buck_pkg::ST_RUN) && enable_in
        && supply_ok_in && boot_ok_in && !thermal_hot_in
        && !valley_over_in && !overshoot_high_in && !q.mask
        && !peak_trip_in;
    endsequence

    sequence s_enter_prebias;
        (q.state == buck_pkg::ST_PREBIAS)
        && ($past(q.state) != buck_pkg::ST_PREBIAS);
    endsequence

    a_no_overlap: assert property (
        !(hs_on_out && ls_on_out))
        else $error("high and low side on together");

    a_dead_gap: assert property (
        $fell(hs_on_out) |-> !ls_on_out [*2])
        else $error("low side on inside the gap");

    a_lockout_off: assert property (
        !supply_ok_in |=> !hs_on_out && !ls_on_out)
        else $error("switch on during lockout");

    a_disable_off: assert property (
        !enable_in |=> !hs_on_out && !ls_on_out && !switching_out)
        else $error("switching while disabled");

    a_boot_hs_off: assert property (
        !boot_ok_in |=> !hs_on_out)
        else $error("high side on with low boot supply");

    a_peak_hs_off: assert property (
        peak_trip_in && hs_on_out |=> !hs_on_out)
        else $error("high side on after peak trip");

    a_ovp_mask: assert property (
        overshoot_high_in |=> !hs_on_out && overshoot_mask_out)
        else $error("high side on above overshoot level");

    a_ovp_release: assert property (
        $fell(overshoot_mask_out) |-> $past(overshoot_low_in))
        else $error("mask released without low comparator");

    a_sink_block: assert property (
        s_sink_trip |=> q.sink_block && !hs_on_out && !ls_on_out)
        else $error("switch on after sink limit");

    a_valley_skip: assert property (
        q.skip |-> !hs_on_out)
        else $error("high side on in a skipped cycle");

    a_cycle_hs_req: assert property (
        s_clean_start |=> q.hs_req)
        else $error("no high side request at cycle start");

    a_prebias_off: assert property (
        (q.state == buck_pkg::ST_PREBIAS) |-> !hs_on_out && !ls_on_out)
        else $error("switch on before ramp passes feedback");

    a_ramp_zero: assert property (
        s_enter_prebias |-> (ss_ramp_out == '0))
        else $error("restart without cleared ramp");

    a_target_min: assert property (
        (target_out <= `REF_CODE)
        && ((target_out == `REF_CODE)
         || (target_out == $past(ss_ramp_out))))
        else $error("target is not lower of ramp and reference");

    a_oc_hiccup: assert property (
        cycle_tick && valley_over_in && enable_in && supply_ok_in
        && !thermal_hot_in && (q.state == buck_pkg::ST_RUN)
        && (q.oc_cnt == `OC_WAIT_CYC) |=> hiccup_out && !hs_on_out)
        else $error("overload did not enter hiccup");

    a_hiccup_exit: assert property (
        oc_done && enable_in && supply_ok_in && !thermal_hot_in
        && hiccup_out |=> (q.state == buck_pkg::ST_PREBIAS))
        else $error("hiccup did not restart");

    a_thermal_stop: assert property (
        thermal_hot_in && enable_in && supply_ok_in
        && (q.state != buck_pkg::ST_OFF) |=> thermal_out && !hs_on_out)
        else $error("switching while overtemperature");

endmodule : buck_switch_sequencer

// file: verif/power_stage_model.sv
module power_stage_model #(
    parameter int unsigned ON_CLKS = 100
) (
    // clock
    input  wire logic mclk_in,
    // gate command and load setting
    input  wire logic hs_on_in,
    input  wire logic limit_en_in,
    // current comparator
    output logic      peak_trip_out
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned on_clks = 0;

    // inductor current ramps only while the high side conducts
    always @(posedge mclk_in) begin
        on_clks <= (hs_on_in === 1'b1) ? on_clks + 1 : 0;
    end

    // light load never reaches the control level
    assign peak_trip_out = limit_en_in & hs_on_in & (on_clks >= ON_CLKS);
endmodule : power_stage_model

// file: verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // stimulus and observed signals
    localparam int HS  = 0;
    localparam int TK  = 2;
    localparam int SWI = 3;
    logic            mclk_in    = 1'b0;
    logic            sys_rst_in = 1'b1;
    logic            enable     = 1'b0;
    logic            supply_ok  = 1'b1;
    logic            boot_ok    = 1'b1;
    logic            th_hot     = 1'b0;
    logic            th_cool    = 1'b0;
    logic            ss_above   = 1'b0;
    logic            ov_high    = 1'b0;
    logic            ov_low     = 1'b1;
    logic            valley     = 1'b0;
    logic            sink       = 1'b0;
    logic            limit_en   = 1'b1;
    logic            peak;
    logic            hs, ls, tick, running, hic, th, mask;
    logic [9:0]      ramp, target;
    wire logic [6:0] st    = {mask, th, hic, running, tick, ls, hs};
    wire logic [9:0] gates = {8'h00, ls, hs};
    wire logic [9:0] stat  = {3'h0, st};
    int              n_mismatch = 0;
    int              n_tests    = 0;
    int              n;

    // ============================================================
    // design and power stage
    buck_switch_sequencer #(.SS_CLKS(5960)) dut (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(enable),
        .supply_ok_in(supply_ok),
        .boot_ok_in(boot_ok),
        .thermal_hot_in(th_hot),
        .thermal_cool_in(th_cool),
        .ss_above_feedback_sense_in(ss_above),
        .peak_trip_in(peak),
        .overshoot_high_in(ov_high),
        .overshoot_low_in(ov_low),
        .valley_over_in(valley),
        .sink_limit_in(sink),
        .hs_on_out(hs),
        .ls_on_out(ls),
        .ss_ramp_out(ramp),
        .target_out(target),
        .cycle_start_out(tick),
        .switching_out(running),
        .hiccup_out(hic),
        .thermal_out(th),
        .overshoot_mask_out(mask)
    );
    power_stage_model #(.ON_CLKS(100)) stage (
        .mclk_in(mclk_in),
        .hs_on_in(hs),
        .limit_en_in(limit_en),
        .peak_trip_out(peak)
    );

    // 200 MHz clock
    always #2.5 mclk_in = ~mclk_in;

    // ============================================================
    // helpers
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // inputs change one ns after the rising edge
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_in);
        #1;
    endtask : cyc

    task automatic wait_bit(input int b, input logic v, output int cnt);
        cnt = 0;
        while (st[b] !== v && cnt < 800) begin
            cyc(1);
            cnt++;
        end
        if (cnt >= 800) begin
            n_mismatch++;
            finish_test();
        end
    endtask : wait_bit

    task automatic wait_tick(output int cnt);
        cyc(1);
        wait_bit(TK, 1'b1, cnt);
    endtask : wait_tick

    // enable, hold in pre-bias, then let the ramp pass feedback
    task automatic start_up(input int hold);
        logic [9:0] r;
        enable   = 1'b1;
        ss_above = 1'b0;
        cyc(2);
        chk(ramp, 10'h000);
        cyc(hold);
        chk(gates, 10'h000);
        chk(10'(ramp < 10'h254), 10'h001);
        r = ramp;
        cyc(1);
        chk(target, r);
        ss_above = 1'b1;
        wait_bit(SWI, 1'b1, n);
        chk(10'(n inside {[1:2]}), 10'h001);
    endtask : start_up

    // switches never both on
    always @(negedge mclk_in) begin
        chk(10'(hs & ls), 10'h000);
    end

    // ============================================================
    // main sequence
    initial begin
        cyc(19);
        chk(stat, 10'h000);
        cyc(1);
        sys_rst_in = 1'b0;
        start_up(5898);
        cyc(100);
        chk(target, 10'h254);
        wait_tick(n);
        wait_tick(n);
        chk(10'(n + 1), 10'h23b);
        // steady cycle, peak trip, then sink limit
        wait_tick(n);
        cyc(3);
        chk(gates, 10'h000);
        cyc(1);
        chk(gates, 10'h001);
        wait_bit(HS, 1'b0, n);
        chk(gates, 10'h000);
        cyc(3);
        chk(gates, 10'h002);
        sink = 1'b1;
        cyc(1);
        sink = 1'b0;
        chk(gates, 10'h000);
        wait_tick(n);
        chk(gates, 10'h000);
        cyc(1);
        chk(gates, 10'h001);
        // valley over limit skips one high-side pulse
        wait_tick(n);
        valley = 1'b1;
        cyc(1);
        valley = 1'b0;
        cyc(8);
        chk(gates, 10'h002);
        wait_tick(n);
        chk(stat & 10'h013, 10'h002);
        cyc(4);
        chk(gates, 10'h001);
        // full duty, then low boot supply
        limit_en = 1'b0;
        wait_tick(n);
        cyc(1);
        chk(gates, 10'h001);
        boot_ok = 1'b0;
        cyc(1);
        chk(gates, 10'h000);
        cyc(3);
        chk(gates, 10'h002);
        boot_ok = 1'b1;
        wait_tick(n);
        cyc(4);
        chk(gates, 10'h001);
        // overshoot mask with hysteresis
        ov_high = 1'b1;
        ov_low  = 1'b0;
        cyc(1);
        ov_high = 1'b0;
        chk(stat & 10'h041, 10'h040);
        wait_tick(n);
        cyc(4);
        chk(stat & 10'h041, 10'h040);
        ov_low = 1'b1;
        cyc(1);
        chk(stat & 10'h041, 10'h000);
        wait_tick(n);
        cyc(4);
        chk(gates, 10'h001);
        // disable, lockout and overtemperature
        enable = 1'b0;
        cyc(1);
        chk(stat & 10'h00b, 10'h000);
        start_up(50);
        wait_tick(n);
        cyc(5);
        supply_ok = 1'b0;
        cyc(1);
        chk(stat & 10'h00b, 10'h000);
        supply_ok = 1'b1;
        start_up(50);
        wait_tick(n);
        cyc(5);
        th_hot = 1'b1;
        cyc(1);
        chk(stat & 10'h02b, 10'h020);
        th_hot  = 1'b0;
        th_cool = 1'b1;
        wait_tick(n);
        wait_tick(n);
        chk(stat & 10'h02b, 10'h020);
        // one cool cycle boundary has been counted so far
        chk(dut.wait_cnt[9:0], 10'h001);
        enable = 1'b0;
        cyc(1);
        chk(stat & 10'h07b, 10'h000);
        finish_test();
    end
endmodule : tb_top
